// *** gtb_timebase.sv ***
// General timer time base with clock source selection, divider and reload counter.
`timescale 1ns/1ps
`default_nettype none

module gtb_timebase #(
  parameter int FILTER_LEN = 4
) (
  // Bus clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins and peer timers.
  input wire logic [3:0] channel_inputs,
  input wire logic ext_trigger_pin,
  input wire logic [3:0] peer_triggers,
  // Cascade and event outputs.
  output logic update_pulse,
  output logic trigger_pulse,
  output logic count_enabled,
  output logic [15:0] counter_value
);

  // The run counters are four bits wide, so longer filters cannot be served.
  if (FILTER_LEN < 2 || FILTER_LEN > 15) begin : gen_bad_filter_len
    $error("FILTER_LEN out of range");
  end

  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic enable;
    logic inhibit;
    logic [1:0] dir_sel;
    logic [24:0] slave;
    logic [2:0] events;
    logic [15:0] count;
    logic [15:0] reload_buf;
    logic [15:0] reload_shadow;
    logic [15:0] divider_buf;
    logic [15:0] divider_active;
    logic [15:0] div_count;
    logic falling;
    logic [1:0] ch_s1;
    logic [1:0] ch_s2;
    logic [1:0] ch_prev;
    logic [1:0] ch_filt;
    logic [1:0][3:0] ch_run;
    logic etr_s1;
    logic etr_s2;
    logic etr_prev;
    logic etr_div;
    logic [2:0] etr_div_cnt;
    logic etr_filt;
    logic [3:0] etr_run;
    logic [3:0] peer_s1;
    logic [3:0] peer_s2;
    logic trig_prev;
    logic upd;
    logic trg;
  } gtb_state_type;

  gtb_state_type state_q;
  gtb_state_type state_d;

  // Register address decoding for the error answer; the read and write paths decode the offsets on their own.
  function automatic logic gtb_mapped(input logic [7:0] addr);
    gtb_mapped = addr <= gtb_pkg::INPUT_OFFSET && addr[1:0] == 2'h0;
  endfunction

  // A short run of equal samples stands for a filter; trades latency for glitch immunity.
  function automatic logic gtb_filter(input logic [3:0] run, input logic [3:0] len,
      input logic cur, input logic old);
    gtb_filter = (run >= len) ? cur : old;
  endfunction

  logic [1:0] mode;
  logic [2:0] trig_sel;
  logic access;
  logic tick;
  logic trig_level;
  logic trig_edge;
  logic [15:0] lim;
  logic ch1_both_edge_pulse;
  logic wrap;
  logic [3:0] flen;

  always_comb begin
    state_d = state_q;
    mode = state_q.slave[gtb_pkg::SLV_MODE_LSB +: 2];
    trig_sel = state_q.slave[gtb_pkg::SLV_TRIG_LSB +: 3];
    access = psel && penable && !state_q.ready;
    flen = 4'(FILTER_LEN);
    lim = state_q.reload_shadow;
    wrap = 1'b0;
    state_d.upd = 1'b0;
    state_d.trg = 1'b0;
    state_d.ready = access;
    state_d.err = access && !gtb_mapped(paddr);

    // Pin synchronisers; only the second stage is used by logic.
    state_d.ch_s1 = channel_inputs[1:0];
    state_d.ch_s2 = state_q.ch_s1;
    state_d.etr_s1 = ext_trigger_pin;
    state_d.etr_s2 = state_q.etr_s1;
    state_d.peer_s1 = peer_triggers;
    state_d.peer_s2 = state_q.peer_s1;

    for (int i = 0; i < 2; i++) begin
      logic p;
      p = state_q.ch_s2[i] ^ state_q.slave[gtb_pkg::SLV_CH_POL_LSB + i];
      state_d.ch_prev[i] = p;
      state_d.ch_run[i] = (p == state_q.ch_prev[i]) ? ((state_q.ch_run[i] == 4'hf) ? 4'hf
          : state_q.ch_run[i] + 4'h1) : 4'h0;
      state_d.ch_filt[i] = gtb_filter(state_q.ch_run[i], flen, p, state_q.ch_filt[i]);
    end
    ch1_both_edge_pulse = state_d.ch_filt[0] ^ state_q.ch_filt[0];

    // Trigger pin: polarity, divide by a power of two, then filter.
    state_d.etr_prev = state_q.etr_s2 ^ state_q.slave[gtb_pkg::SLV_ETR_POL_BIT];
    if (state_d.etr_prev && !state_q.etr_prev) begin
      state_d.etr_div_cnt = state_q.etr_div_cnt + 3'h1;
    end
    // Bit k of the edge counter toggles once every two to the k rising edges.
    case (state_q.slave[gtb_pkg::SLV_ETR_DIV_LSB +: 2])
      2'h0: state_d.etr_div = state_q.etr_prev;
      2'h1: state_d.etr_div = state_q.etr_div_cnt[0];
      2'h2: state_d.etr_div = state_q.etr_div_cnt[1];
      default: state_d.etr_div = state_q.etr_div_cnt[2];
    endcase
    state_d.etr_run = (state_d.etr_div == state_q.etr_div) ? ((state_q.etr_run == 4'hf) ? 4'hf
        : state_q.etr_run + 4'h1) : 4'h0;
    state_d.etr_filt = gtb_filter(state_q.etr_run, state_q.slave[gtb_pkg::SLV_ETR_FLT_LSB +: 4],
        state_q.etr_div, state_q.etr_filt);

    case (trig_sel)
      gtb_pkg::TRG_CH1_EDGE: trig_level = ch1_both_edge_pulse;
      gtb_pkg::TRG_CH1: trig_level = state_q.ch_filt[0];
      gtb_pkg::TRG_CH2: trig_level = state_q.ch_filt[1];
      gtb_pkg::TRG_ETR: trig_level = state_q.etr_filt;
      default: trig_level = state_q.peer_s2[trig_sel[1:0]];
    endcase
    state_d.trig_prev = trig_level;
    trig_edge = (trig_sel == gtb_pkg::TRG_CH1_EDGE) ? trig_level : (trig_level && !state_q.trig_prev);

    // Clock source selection for the divider input.
    case (mode)
      gtb_pkg::SRC_INTERNAL: tick = state_q.enable;
      gtb_pkg::SRC_EXT_ONE: tick = state_q.enable && trig_edge && trig_sel != gtb_pkg::TRG_ETR;
      gtb_pkg::SRC_EXT_TWO: tick = state_q.enable && state_d.etr_filt && !state_q.etr_filt;
      gtb_pkg::SRC_INT_TRIG: tick = state_q.enable && trig_edge;
      default: tick = 1'b0;
    endcase
    if (mode != gtb_pkg::SRC_INTERNAL) begin
      state_d.trg = trig_edge;
    end

    // Divider: counts divider_active plus one input ticks per counter step.
    if (tick) begin
      if (state_q.div_count >= state_q.divider_active) begin
        state_d.div_count = 16'h0000;
        case (state_q.dir_sel)
          gtb_pkg::DIR_UP: begin
            wrap = state_q.count >= lim;
            state_d.count = wrap ? 16'h0000 : state_q.count + 16'h0001;
          end
          gtb_pkg::DIR_DOWN: begin
            wrap = state_q.count == 16'h0000;
            state_d.count = wrap ? lim : state_q.count - 16'h0001;
          end
          gtb_pkg::DIR_CENTER: begin
            if (!state_q.falling) begin
              wrap = state_q.count == lim - 16'h0001;
              state_d.count = state_q.count + 16'h0001;
              state_d.falling = state_d.count >= lim;
            end else begin
              wrap = state_q.count == 16'h0001;
              state_d.count = state_q.count - 16'h0001;
              state_d.falling = state_d.count != 16'h0000;
            end
          end
          default: state_d.count = state_q.count;
        endcase
      end else begin
        state_d.div_count = state_q.div_count + 16'h0001;
      end
    end

    // Update event loads the shadows unless inhibited.
    if (wrap && !state_q.inhibit) begin
      state_d.upd = 1'b1;
      state_d.reload_shadow = state_q.reload_buf;
      state_d.divider_active = state_q.divider_buf;
    end

    // Register writes.
    if (access && pwrite) begin
      case (paddr)
        gtb_pkg::CTRL_ONE_OFFSET: begin
          state_d.enable = pwdata[gtb_pkg::CTRL_ENABLE_BIT];
          state_d.inhibit = pwdata[gtb_pkg::CTRL_INHIBIT_BIT];
          state_d.dir_sel = pwdata[gtb_pkg::CTRL_DIR_LSB +: gtb_pkg::CTRL_DIR_W];
        end
        gtb_pkg::SLAVE_OFFSET: begin
          state_d.slave = pwdata[24:0];
          if (pwdata[gtb_pkg::SLV_PWM_IN_BIT] && pwdata[gtb_pkg::SLV_TRIG_LSB +: 3] != gtb_pkg::TRG_CH1
              && pwdata[gtb_pkg::SLV_TRIG_LSB +: 3] != gtb_pkg::TRG_CH2) begin
            state_d.slave[gtb_pkg::SLV_PWM_IN_BIT] = 1'b0;
            state_d.events[2] = 1'b1;
          end
        end
        gtb_pkg::EVENT_OFFSET: begin
          if (pwdata[gtb_pkg::EV_UPDATE_BIT]) state_d.events[0] = 1'b0;
          if (pwdata[gtb_pkg::EV_TRIGGER_BIT]) state_d.events[1] = 1'b0;
          if (pwdata[gtb_pkg::EV_PWM_REFUSED_BIT]) state_d.events[2] = 1'b0;
        end
        gtb_pkg::GEN_OFFSET: begin
          if (pwdata[0]) begin
            state_d.count = (state_q.dir_sel == gtb_pkg::DIR_DOWN) ? state_q.reload_buf : 16'h0000;
            state_d.div_count = 16'h0000;
            state_d.falling = 1'b0;
            state_d.reload_shadow = state_q.reload_buf;
            state_d.divider_active = state_q.divider_buf;
            state_d.upd = !state_q.inhibit;
          end
        end
        gtb_pkg::COUNT_OFFSET: state_d.count = pwdata[15:0];
        gtb_pkg::DIVIDER_OFFSET: state_d.divider_buf = pwdata[15:0];
        gtb_pkg::RELOAD_OFFSET: state_d.reload_buf = pwdata[15:0];
        default: state_d.enable = state_q.enable;
      endcase
    end

    // Sticky flags; hardware setting wins over a same-cycle clear.
    if (state_d.upd) state_d.events[0] = 1'b1;
    if (state_d.trg) state_d.events[1] = 1'b1;

    state_d.rdata = 32'h0000_0000;
    if (access && !pwrite) begin
      case (paddr)
        gtb_pkg::CTRL_ONE_OFFSET: state_d.rdata = {26'h0, state_q.dir_sel, 2'h0, state_q.inhibit,
            state_q.enable};
        gtb_pkg::SLAVE_OFFSET: state_d.rdata = {7'h0, state_q.slave};
        gtb_pkg::EVENT_OFFSET: state_d.rdata = {23'h0, state_q.events[2], 1'b0, state_q.events[1],
            5'h0, state_q.events[0]};
        gtb_pkg::COUNT_OFFSET: state_d.rdata = {16'h0, state_q.count};
        gtb_pkg::DIVIDER_OFFSET: state_d.rdata = {16'h0, state_q.divider_buf};
        gtb_pkg::RELOAD_OFFSET: state_d.rdata = {16'h0, state_q.reload_buf};
        gtb_pkg::INPUT_OFFSET: state_d.rdata = {26'h0, state_q.falling, state_q.etr_filt,
            2'h0, state_q.ch_filt};
        default: state_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
      state_q.reload_buf <= gtb_pkg::RELOAD_RESET;
      state_q.reload_shadow <= gtb_pkg::RELOAD_RESET;
      state_q.divider_buf <= gtb_pkg::DIVIDER_RESET;
      state_q.divider_active <= gtb_pkg::DIVIDER_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Cascade outputs let peers synchronise to this instance without coupling its state.
  assign prdata = state_q.rdata;
  assign pready = state_q.ready;
  assign pslverr = state_q.err;
  assign update_pulse = state_q.upd;
  assign trigger_pulse = state_q.trg;
  assign count_enabled = state_q.enable;
  assign counter_value = state_q.count;

endmodule

`default_nettype wire

// *** gtb_pkg.sv ***
// Package with register map, field positions and encodings of the timer time base.
package gtb_pkg;

  // Register byte offsets.
  localparam logic [7:0] CTRL_ONE_OFFSET = 8'h00;
  localparam logic [7:0] SLAVE_OFFSET = 8'h04;
  localparam logic [7:0] EVENT_OFFSET = 8'h08;
  localparam logic [7:0] GEN_OFFSET = 8'h0c;
  localparam logic [7:0] COUNT_OFFSET = 8'h10;
  localparam logic [7:0] DIVIDER_OFFSET = 8'h14;
  localparam logic [7:0] RELOAD_OFFSET = 8'h18;
  localparam logic [7:0] INPUT_OFFSET = 8'h1c;

  // Control register one fields.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_INHIBIT_BIT = 1;
  localparam int CTRL_DIR_LSB = 4;
  localparam int CTRL_DIR_W = 2;

  // Slave control fields.
  localparam int SLV_MODE_LSB = 0;
  localparam int SLV_TRIG_LSB = 4;
  localparam int SLV_ETR_POL_BIT = 8;
  localparam int SLV_ETR_DIV_LSB = 9;
  localparam int SLV_ETR_FLT_LSB = 12;
  localparam int SLV_CH_POL_LSB = 16;
  localparam int SLV_CH_FLT_LSB = 20;
  localparam int SLV_PWM_IN_BIT = 24;

  // Event register bits; written one to clear.
  localparam int EV_UPDATE_BIT = 0;
  localparam int EV_TRIGGER_BIT = 6;
  localparam int EV_PWM_REFUSED_BIT = 8;

  // Counting modes.
  localparam logic [1:0] DIR_UP = 2'h0;
  localparam logic [1:0] DIR_DOWN = 2'h1;
  localparam logic [1:0] DIR_CENTER = 2'h2;

  // Clock source selection.
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_EXT_ONE = 2'h1;
  localparam logic [1:0] SRC_EXT_TWO = 2'h2;
  localparam logic [1:0] SRC_INT_TRIG = 2'h3;

  // Trigger selection for the slave controller.
  localparam logic [2:0] TRG_PEER0 = 3'h0;
  localparam logic [2:0] TRG_PEER1 = 3'h1;
  localparam logic [2:0] TRG_PEER2 = 3'h2;
  localparam logic [2:0] TRG_PEER3 = 3'h3;
  localparam logic [2:0] TRG_CH1_EDGE = 3'h4;
  localparam logic [2:0] TRG_CH1 = 3'h5;
  localparam logic [2:0] TRG_CH2 = 3'h6;
  localparam logic [2:0] TRG_ETR = 3'h7;

  // Reset values.
  localparam logic [15:0] RELOAD_RESET = 16'hffff;
  localparam logic [15:0] DIVIDER_RESET = 16'h0000;

endpackage

// *** gtb_properties.sv ***
// Checker of the port timing of the timer time base.
`timescale 1ns/1ps
`default_nettype none
module gtb_properties (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events and count.
  input wire logic update_pulse,
  input wire logic trigger_pulse,
  input wire logic count_enabled,
  input wire logic [15:0] counter_value
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  answer_in_time_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  count_hold_a: assert property (!count_enabled && !(psel && penable) |=> $stable(counter_value))
    else $error("counter moved while stopped");
  enable_by_write_a: assert property ($changed(count_enabled) |-> $past(psel && penable && pwrite))
    else $error("enable changed without write");
  update_single_a: assert property (update_pulse |=> !update_pulse)
    else $error("update pulse too long");
  cover property (update_pulse);
  cover property (trigger_pulse);
  cover property (pslverr);
endmodule
bind gtb_timebase gtb_properties gtb_properties_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .update_pulse(update_pulse), .trigger_pulse(trigger_pulse), .count_enabled(count_enabled),
  .counter_value(counter_value));
`default_nettype wire

// *** gtb_pins.sv ***
// Model of the input pins and peer timers that clock the time base.
`timescale 1ns/1ps
`default_nettype none
module gtb_pins (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Requests from the bench.
  input wire logic run,
  input wire logic [1:0] which,
  input wire logic [7:0] half,
  // Driven pins.
  output logic [3:0] channel_inputs,
  output logic ext_trigger_pin,
  output logic [3:0] peer_triggers
);
  logic [7:0] cnt_q;
  logic lvl_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn || !run) begin
      cnt_q <= 8'h00;
      lvl_q <= 1'b0;
    end else if (cnt_q == half - 8'h01) begin
      cnt_q <= 8'h00;
      lvl_q <= !lvl_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // The source stands still at low between runs, as an idle pin would.
  assign channel_inputs = {3'h0, lvl_q && which == 2'h0};
  assign ext_trigger_pin = lvl_q && which == 2'h1;
  assign peer_triggers = {3'h0, lvl_q && which == 2'h2};
endmodule
`default_nettype wire

// *** gtb_timebase_bench.sv ***
// Self-checking bench for the timer time base.
`timescale 1ns/1ps
`default_nettype none
module gtb_timebase_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, run;
  logic ext_trigger_pin, update_pulse, trigger_pulse, count_enabled;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] channel_inputs, peer_triggers;
  logic [15:0] counter_value;
  logic [1:0] which;
  int failures, checks, cycles, n;
  gtb_timebase gtb_timebase_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channel_inputs(channel_inputs), .ext_trigger_pin(ext_trigger_pin),
    .peer_triggers(peer_triggers), .update_pulse(update_pulse), .trigger_pulse(trigger_pulse),
    .count_enabled(count_enabled), .counter_value(counter_value));
  gtb_pins gtb_pins_i (.pclk(pclk), .presetn(presetn), .run(run), .which(which), .half(8'h08),
    .channel_inputs(channel_inputs), .ext_trigger_pin(ext_trigger_pin), .peer_triggers(peer_triggers));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = !pclk;
  end
  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      $display("[FAIL] %0t timeout", $time);
      test_done;
    end
  end
  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Cycles up to the next update pulse; the first call only synchronises.
  task automatic gap(output int g);
    g = 0;
    do begin
      @(posedge pclk);
      g++;
    end while (update_pulse !== 1'b1 && g < 4000);
  endtask
  task automatic per(input int exp, input string msg);
    gap(n);
    gap(n);
    chk(n == exp, msg);
  endtask
  task automatic cfg(input logic [1:0] dir, input logic [15:0] div, input logic [15:0] lim, input logic inh);
    // Direction and inhibit must stand before the reinitialisation, which picks the start value from the direction and the update pulse from inhibit.
    apb(1'b1, gtb_pkg::CTRL_ONE_OFFSET, {26'h0, dir, 2'h0, inh, 1'b0});
    apb(1'b1, gtb_pkg::DIVIDER_OFFSET, {16'h0, div});
    apb(1'b1, gtb_pkg::RELOAD_OFFSET, {16'h0, lim});
    apb(1'b1, gtb_pkg::GEN_OFFSET, 32'h1);
    apb(1'b1, gtb_pkg::CTRL_ONE_OFFSET, {26'h0, dir, 2'h0, inh, 1'b1});
  endtask
  task automatic t_reset;
    apb(1'b0, gtb_pkg::RELOAD_OFFSET, 32'h0);
    chk(rdata === 32'h0000ffff, "reload reset");
    apb(1'b0, gtb_pkg::DIVIDER_OFFSET, 32'h0);
    chk(rdata === 32'h0, "divider reset");
    apb(1'b0, 8'h40, 32'h0);
    chk(err === 1'b1 && rdata === 32'h0, "unmapped read");
  endtask
  task automatic t_modes;
    cfg(gtb_pkg::DIR_UP, 16'h03e7, 16'h0004, 1'b0);
    apb(1'b0, gtb_pkg::COUNT_OFFSET, 32'h0);
    chk(rdata === 32'h0, "up start");
    chk(count_enabled === 1'b1 && counter_value === 16'h0000, "up start outputs");
    cfg(gtb_pkg::DIR_DOWN, 16'h03e7, 16'h0004, 1'b0);
    apb(1'b0, gtb_pkg::COUNT_OFFSET, 32'h0);
    chk(rdata === 32'h4, "down start");
    chk(counter_value === 16'h0004, "down start output");
    cfg(gtb_pkg::DIR_UP, 16'h0000, 16'h0004, 1'b0);
    per(5, "up period");
    cfg(gtb_pkg::DIR_DOWN, 16'h0000, 16'h0004, 1'b0);
    per(5, "down period");
    cfg(gtb_pkg::DIR_CENTER, 16'h0000, 16'h0004, 1'b0);
    per(4, "center period");
    cfg(gtb_pkg::DIR_UP, 16'h0002, 16'h0004, 1'b0);
    per(15, "divided period");
    apb(1'b1, gtb_pkg::DIVIDER_OFFSET, 32'h0);
    per(5, "divider reloaded");
  endtask
  task automatic t_buffer;
    cfg(gtb_pkg::DIR_UP, 16'h0000, 16'h0028, 1'b0);
    gap(n);
    gap(n);
    apb(1'b1, gtb_pkg::RELOAD_OFFSET, 32'h9);
    gap(n);
    chk(n > 30, "reload not buffered");
    gap(n);
    chk(n == 10, "reload after update");
    cfg(gtb_pkg::DIR_UP, 16'h0000, 16'h0004, 1'b1);
    n = 0;
    repeat (60) begin
      @(posedge pclk);
      if (update_pulse === 1'b1) n++;
    end
    chk(n == 0, "inhibited update");
  endtask
  task automatic src_run(input logic [1:0] src, input logic [2:0] trig, input logic [1:0] pin, input int exp);
    run <= 1'b0;
    which <= pin;
    apb(1'b1, gtb_pkg::SLAVE_OFFSET, {25'h0, trig, 2'h0, src});
    cfg(gtb_pkg::DIR_UP, 16'h0000, 16'h0004, 1'b0);
    run <= 1'b1;
    per(exp, "external clock period");
    // Every selected trigger edge is one counter step, so one period holds five of them.
    n = 0;
    repeat (exp) begin
      @(posedge pclk);
      if (trigger_pulse === 1'b1) n++;
    end
    chk(n == 5, "trigger pulses per period");
    run <= 1'b0;
  endtask
  task automatic t_pwm;
    apb(1'b1, gtb_pkg::SLAVE_OFFSET, {7'h0, 1'b1, 17'h0, gtb_pkg::TRG_ETR, 4'h0});
    apb(1'b0, gtb_pkg::SLAVE_OFFSET, 32'h0);
    chk(rdata[24] === 1'b0, "pwm on pin kept");
    apb(1'b0, gtb_pkg::EVENT_OFFSET, 32'h0);
    chk(rdata[8] === 1'b1, "pwm refusal flag");
    apb(1'b1, gtb_pkg::EVENT_OFFSET, 32'h0000_0100);
    apb(1'b0, gtb_pkg::EVENT_OFFSET, 32'h0);
    chk(rdata[8] === 1'b0, "pwm refusal flag cleared");
    apb(1'b1, gtb_pkg::SLAVE_OFFSET, {7'h0, 1'b1, 17'h0, gtb_pkg::TRG_CH2, 4'h0});
    apb(1'b0, gtb_pkg::SLAVE_OFFSET, 32'h0);
    chk(rdata[24] === 1'b1, "pwm on channel two");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run = 1'b0;
    which = 2'h0;
    failures = 0;
    checks = 0;
    cycles = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_modes;
    t_buffer;
    src_run(gtb_pkg::SRC_EXT_ONE, gtb_pkg::TRG_CH1, 2'h0, 80);
    src_run(gtb_pkg::SRC_EXT_ONE, gtb_pkg::TRG_CH1_EDGE, 2'h0, 40);
    src_run(gtb_pkg::SRC_EXT_TWO, gtb_pkg::TRG_ETR, 2'h1, 80);
    src_run(gtb_pkg::SRC_INT_TRIG, gtb_pkg::TRG_PEER0, 2'h2, 80);
    t_pwm;
    test_done;
  end
endmodule
`default_nettype wire
